// ### rtl/dma_protected_region_gate.sv
// Protected memory region enable, status and DMA blocking decision
//
// How it works
// - Enable clear: no region blocking at all
// - Remapping off: block every protected-region hit
// - Pass-through translation type hits are blocked
// - Already-translated address hits are blocked
// - Translated request hits: blocking is selectable
// - Unit's own structure fetches never blocked
// - Status bit reads one while regions active
// - Drain in-flight translated requests before status
// - No region support: enable register read-only
// - Low base reserved bits decode as zero
// - Low limit below base disables region
`include "pmr_consts.svh"
module dma_protected_region_gate import pmr_pkg::*; #(
    parameter int LOW_RSVD     = `PMR_LO_RSVD, // Reserved low bits of low bounds
    parameter bit BLOCK_XLATED = 1'b0,         // Block translated-request hits
    parameter bit SUPPORT_DRAIN = 1'b1         // Wait for drain before status
) (
    input  wire logic        sys_clk,               // Unit clock
    input  wire logic        nrst,                  // Async reset, active low
    input  wire logic [11:0] reg_addr,              // Register byte address
    input  wire logic [31:0] reg_wdata,             // Write data
    input  wire logic        reg_wr,                // Write strobe
    input  wire logic        reg_rd,                // Read strobe
    output logic      [31:0] reg_rdata,             // Read data, cycle after strobe
    input  wire logic        low_region_supported,  // Capability: low region
    input  wire logic        high_region_supported, // Capability: high region
    input  wire logic        remap_enable,          // Address remapping on
    input  wire logic        xlat_inflight,         // Translated requests queued
    input  wire logic        req_valid,             // DMA request present
    input  wire logic [63:0] req_addr,              // DMA target address
    input  wire logic [1:0]  req_tt,                // Context translation type
    input  wire logic [1:0]  req_at,                // Address type field
    input  wire logic        req_self,              // Unit's own structure fetch
    output logic             resp_valid,            // Decision valid
    output logic             resp_block,            // Request blocked
    output logic             protect_status         // Regions active
);
    // Elaboration check: low bounds need reserved bits and field bits
    if (LOW_RSVD < 1 || LOW_RSVD > 31) begin : g_bad_low_rsvd
        $error("LOW_RSVD out of range");
    end

    // Register state
    logic        protect_enable_r;  // Enable bit
    logic [31:0] lo_base_r;         // Low region base
    logic [31:0] lo_lim_r;          // Low region limit
    logic [31:0] hi_base_r;         // High region base, 4 KB units
    logic [31:0] hi_lim_r;          // High region limit, 4 KB units
    gate_state_t state_r;           // Status sequencer
    gate_state_t state_nxt;         // Next sequencer state
    logic [31:0] rdata_r;           // Read data register
    logic        resp_valid_r;      // Decision valid register
    logic        resp_block_r;      // Decision register

    // Address decode
    wire logic sel_en  = (reg_addr == `PMR_OFF_ENABLE);
    wire logic sel_lb  = (reg_addr == `PMR_OFF_LO_BASE);
    wire logic sel_ll  = (reg_addr == `PMR_OFF_LO_LIM);
    wire logic sel_hb  = (reg_addr == `PMR_OFF_HI_BASE);
    wire logic sel_hl  = (reg_addr == `PMR_OFF_HI_LIM);
    wire logic any_sup = low_region_supported | high_region_supported;
    wire logic wr_en   = reg_wr & sel_en & any_sup;
    wire logic wr_lo   = reg_wr & low_region_supported;
    wire logic wr_hi   = reg_wr & high_region_supported;

    // Low bound masks: reserved bits are stored as zero
    wire logic [31:0] lo_mask = ~((32'h0000_0001 << LOW_RSVD) - 32'h0000_0001);

    // Read mux
    wire logic [31:0] rd_val =
        sel_en ? {protect_enable_r, 30'h0000_0000, state_r == ST_ON} :
        sel_lb ? lo_base_r :
        sel_ll ? lo_lim_r :
        sel_hb ? hi_base_r :
        sel_hl ? hi_lim_r : 32'h0000_0000;

    // Enable bit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            protect_enable_r <= `PMR_RST_ENABLE;
        end else if (wr_en) begin
            protect_enable_r <= reg_wdata[`PMR_ENABLE_BIT];
        end
    end

    // Low region bounds, writable only when supported
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lo_base_r <= `PMR_RST_BOUND;
            lo_lim_r  <= `PMR_RST_BOUND;
        end else begin
            if (wr_lo && sel_lb) lo_base_r <= reg_wdata & lo_mask;
            if (wr_lo && sel_ll) lo_lim_r  <= reg_wdata & lo_mask;
        end
    end

    // High region bounds, writable only when supported
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hi_base_r <= `PMR_RST_BOUND;
            hi_lim_r  <= `PMR_RST_BOUND;
        end else begin
            if (wr_hi && sel_hb) hi_base_r <= reg_wdata;
            if (wr_hi && sel_hl) hi_lim_r  <= reg_wdata;
        end
    end

    // Read data, one cycle after the strobe only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= reg_rd ? rd_val : 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_r;

    // Status sequencer: enable, wait for drain, then report
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (protect_enable_r) state_nxt = ST_DRAIN;
            end
            ST_DRAIN: begin
                if (!protect_enable_r) begin
                    state_nxt = ST_OFF;
                end else if (!SUPPORT_DRAIN || !xlat_inflight) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (!protect_enable_r) state_nxt = ST_OFF;
            end
            default: state_nxt = ST_OFF;
        endcase
    end

    // Sequencer state
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign protect_status = (state_r == ST_ON);

    // Region hits
    logic lo_hit;  // Low region hit
    logic hi_hit;  // High region hit
    region_match #(.W(32), .RSV(LOW_RSVD)) u_lo (
        .base  (lo_base_r),
        .limit (lo_lim_r),
        .addr  (req_addr[31:0]),
        .hit   (lo_hit)
    );
    region_match #(.W(32), .RSV(0)) u_hi (
        .base  (hi_base_r),
        .limit (hi_lim_r),
        .addr  (req_addr[`PMR_HI_SHIFT+31:`PMR_HI_SHIFT]),
        .hit   (hi_hit)
    );
    wire logic lo_in  = lo_hit & low_region_supported & (req_addr[63:32] == 32'h0000_0000);
    wire logic hi_in  = hi_hit & high_region_supported & (req_addr[63:44] == 20'h00000);
    wire logic in_reg = lo_in | hi_in;

    // Request class that is subject to blocking
    wire logic cls_pass = (req_tt == `PMR_TT_PASS);
    wire logic cls_at   = (req_at == `PMR_AT_XLATED);
    wire logic cls_blk  = !remap_enable | cls_pass | cls_at | BLOCK_XLATED;
    // Blocking follows the enable bit directly; own fetches exempt
    wire logic blk_now  = req_valid & !req_self & protect_enable_r & in_reg & cls_blk;

    // Registered decision
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            resp_valid_r <= 1'b0;
            resp_block_r <= 1'b0;
        end else begin
            resp_valid_r <= req_valid;
            resp_block_r <= blk_now;
        end
    end
    assign resp_valid = resp_valid_r;
    assign resp_block = resp_block_r;

    // Checks
    sequence s_disable;
        !protect_enable_r ##1 !protect_enable_r;
    endsequence
    sequence s_hit_req;
        req_valid && !req_self && protect_enable_r && in_reg;
    endsequence

    AST_OFF_NO_BLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
        req_valid && !protect_enable_r |=> !resp_block)
        else $error("block while protection disabled");
    AST_NOREMAP_BLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_hit_req and !remap_enable |=> resp_valid && resp_block)
        else $error("remap-off hit not blocked");
    AST_PASS_BLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_hit_req and req_tt == `PMR_TT_PASS |=> resp_block)
        else $error("pass-through hit not blocked");
    AST_AT_BLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_hit_req and req_at == `PMR_AT_XLATED |=> resp_block)
        else $error("translated-address hit not blocked");
    AST_SELF_FREE: assert property (@(posedge sys_clk) disable iff (!nrst)
        req_valid && req_self |=> resp_valid && !resp_block)
        else $error("own fetch blocked");
    AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_rd && sel_en |=> reg_rdata[`PMR_STATUS_BIT] == $past(protect_status))
        else $error("status bit read wrong");
    AST_DRAIN_FIRST: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(protect_status) |-> $past(protect_enable_r)
            && (!SUPPORT_DRAIN || !$past(xlat_inflight)))
        else $error("status set before drain");
    AST_RO_NO_SUPPORT: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && sel_en && !any_sup |=> $stable(protect_enable_r))
        else $error("enable written without support");
    AST_LOW_BASE_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_rd && sel_lb |=> (reg_rdata & ~lo_mask) == 32'h0000_0000)
        else $error("low base reserved bits nonzero");
    AST_LIMIT_BELOW: assert property (@(posedge sys_clk) disable iff (!nrst)
        lo_lim_r[31:LOW_RSVD] < lo_base_r[31:LOW_RSVD] |-> !lo_hit)
        else $error("inverted low region still hits");
    AST_STATUS_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!nrst)
        s_disable |-> !protect_status)
        else $error("status stays after disable");
endmodule

// ### rtl/pmr_consts.svh
// Register offsets, field positions, reset values and codes of the DMA protected-region gate
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH
`define PMR_OFF_ENABLE   12'h064
`define PMR_OFF_LO_BASE  12'h068
`define PMR_OFF_LO_LIM   12'h06c
`define PMR_OFF_HI_BASE  12'h070
`define PMR_OFF_HI_LIM   12'h074
`define PMR_ENABLE_BIT   31
`define PMR_STATUS_BIT   0
`define PMR_RST_ENABLE   1'b0
`define PMR_RST_BOUND    32'h0000_0000
`define PMR_TT_PASS      2'h2
`define PMR_AT_XLATED    2'h2
`define PMR_HI_SHIFT     12
`define PMR_LO_RSVD      20
`endif

// ### rtl/pmr_pkg.sv
// Types shared by the DMA protected-region gate
package pmr_pkg;
    // Protection status sequencer
    typedef enum logic [1:0] {ST_OFF, ST_DRAIN, ST_ON} gate_state_t;
endpackage

// ### rtl/region_match.sv
// Address window test of one protected region against base and limit fields
module region_match #(
    parameter int W   = 32,  // Compared address width
    parameter int RSV = 0    // Low bits decoded as zero in base, one in limit
) (
    input  wire logic [W-1:0] base,   // Programmed base
    input  wire logic [W-1:0] limit,  // Programmed limit
    input  wire logic [W-1:0] addr,   // Request address bits
    output wire logic         hit     // Address within an active region
);
    // Elaboration check: at least one compared bit must remain
    if (RSV < 0 || RSV >= W) begin : g_bad_rsv
        $error("region_match: RSV out of range");
    end
    // Only upper fields matter: low bits are zero in base and one in limit
    wire logic [W-1:RSV] base_f  = base[W-1:RSV];
    wire logic [W-1:RSV] limit_f = limit[W-1:RSV];
    wire logic [W-1:RSV] addr_f  = addr[W-1:RSV];
    // Limit below base leaves the region disabled
    wire logic           valid   = (limit_f >= base_f);
    assign hit = valid && (addr_f >= base_f) && (addr_f <= limit_f);
endmodule

// ### bench/dma_source_model.sv
// DMA request source and translation queue model facing the protected-region gate
module dma_source_model (
    input  wire logic        sys_clk,       // Unit clock
    output logic             req_valid,     // Request present
    output logic      [63:0] req_addr,      // Target address
    output logic      [1:0]  req_tt,        // Context translation type
    output logic      [1:0]  req_at,        // Address type
    output logic             req_self,      // Own structure fetch
    output logic             xlat_inflight  // Translated requests queued
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle lines at time zero
    initial begin
        req_valid = 1'b0;
        req_addr = 64'h0;
        req_tt = 2'h0;
        req_at = 2'h0;
        req_self = 1'b0;
        xlat_inflight = 1'b0;
    end
    // One request per cycle; an idle cycle shows inverted address, not a stale one
    task automatic issue(input logic v, input logic [63:0] a, input logic [1:0] t,
                         input logic [1:0] at, input logic s);
        @(posedge sys_clk);
        req_valid <= v;
        req_addr <= v ? a : ~a;
        req_tt <= t;
        req_at <= at;
        req_self <= s;
    endtask
    // Translated traffic stays queued for n cycles
    task automatic drain(input int n);
        @(posedge sys_clk);
        xlat_inflight <= 1'b1;
        repeat (n) @(posedge sys_clk);
        xlat_inflight <= 1'b0;
    endtask
endmodule

// ### bench/dma_protected_region_gate_bench.sv
// Self-checking bench of the protected-region gate against a behavioural model
`include "pmr_consts.svh"
module dma_protected_region_gate_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, nrst, reg_wr, reg_rd, lo_sup, hi_sup, remap_enable, en;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd, lb, ll, hb, hl;
    logic [63:0] req_addr;
    logic [1:0]  req_tt, req_at;
    logic        req_valid, req_self, xlat_inflight, resp_valid, resp_block, protect_status;
    int          n_fail, checks;
    logic [1:0]  q[$];
    logic [63:0] bases[5] = '{64'h0fe0_0000, 64'h101e_0000, 64'hffe0_0000, 64'h1_000e_0000,
                              64'h1_1000_0000};
    dma_protected_region_gate dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .low_region_supported(lo_sup), .high_region_supported(hi_sup),
        .remap_enable(remap_enable), .xlat_inflight(xlat_inflight), .req_valid(req_valid),
        .req_addr(req_addr), .req_tt(req_tt), .req_at(req_at), .req_self(req_self),
        .resp_valid(resp_valid), .resp_block(resp_block), .protect_status(protect_status));
    dma_source_model src_u (.sys_clk(sys_clk), .req_valid(req_valid), .req_addr(req_addr),
        .req_tt(req_tt), .req_at(req_at), .req_self(req_self), .xlat_inflight(xlat_inflight));
    // Clock at 25 MHz
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Watchdog against a hang
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    // Count a comparison and report a mismatch
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle
    task automatic rdr(input logic [11:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd = reg_rdata;
    endtask
    // Model of the region windows; low bounds drop their reserved bits
    function automatic logic hit(input logic [63:0] a);
        logic lo, hi;
        lo = a[63:32] == 0 && ll[31:20] >= lb[31:20] && a[31:20] >= lb[31:20]
             && a[31:20] <= ll[31:20];
        hi = a[63:44] == 0 && a[43:12] >= hb && a[43:12] <= hl;
        return lo || hi;
    endfunction
    // Random request stream, each decision compared one cycle later
    task automatic run(input int n);
        logic [63:0] a;
        logic [1:0]  t, at;
        logic        v, s, r, b;
        for (int k = 0; k <= n; k++) begin
            v = (k < n) && $urandom_range(3) != 0;
            a = bases[$urandom_range(4)] + 64'($urandom_range(32'h3f_ffff));
            t = 2'($urandom_range(3));
            at = 2'($urandom_range(3));
            s = $urandom_range(7) == 0;
            r = 1'($urandom_range(1));
            src_u.issue(v, a, t, at, s);
            remap_enable <= r;
            // Translated hits pass; software must not lean on them
            b = en && !s && hit(a) && (!r || t == `PMR_TT_PASS || at == `PMR_AT_XLATED);
            q.push_back({v, b});
            @(negedge sys_clk);
            if (q.size() == 2) begin
                {v, b} = q.pop_front();
                chk("resp_valid", resp_valid, v);
                if (v) chk("resp_block", resp_block, b);
            end
        end
        q.delete();
    endtask
    // Print the counts and the verdict, then stop
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {nrst, reg_wr, reg_rd, lo_sup, hi_sup, remap_enable, en} = 7'h0;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        n_fail = 0;
        checks = 0;
        void'($urandom(27758));
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        chk("protect_status", protect_status, 0);
        wr(`PMR_OFF_ENABLE, 32'h8000_0000);
        rdr(`PMR_OFF_ENABLE);
        chk("enable_no_support", rd, 0);
        @(posedge sys_clk);
        lo_sup <= 1'b1;
        hi_sup <= 1'b1;
        lb = 32'h1000_0000;
        ll = 32'h1010_0000;
        hb = 32'h0010_0000;
        hl = 32'h0010_00ff;
        wr(`PMR_OFF_LO_BASE, 32'h1000_0fff);
        wr(`PMR_OFF_LO_LIM, ll);
        wr(`PMR_OFF_HI_BASE, hb);
        wr(`PMR_OFF_HI_LIM, hl);
        rdr(`PMR_OFF_LO_BASE);
        chk("low_base", rd, lb);
        rdr(12'h0fc);
        chk("unmapped", rd, 0);
        run(300);
        fork
            src_u.drain(6);
            wr(`PMR_OFF_ENABLE, 32'h8000_0000);
        join
        en = 1'b1;
        @(negedge sys_clk);
        chk("status_draining", protect_status, 0);
        repeat (2) @(posedge sys_clk);
        rdr(`PMR_OFF_ENABLE);
        chk("enable_on", rd, 32'h8000_0001);
        run(300);
        wr(`PMR_OFF_ENABLE, 32'h0);
        en = 1'b0;
        @(negedge sys_clk);
        chk("status_hold", protect_status, 1);
        @(negedge sys_clk);
        chk("status_off", protect_status, 0);
        ll = 32'h0f00_0000;
        wr(`PMR_OFF_LO_LIM, ll);
        wr(`PMR_OFF_ENABLE, 32'h8000_0000);
        en = 1'b1;
        run(200);
        print_verdict();
    end
endmodule
